/* delta_outputs.sv */
// Purpose: delta angle / delta velocity result registers behind an APB slave
// Assumes: rate and accel samples arrive with one shared sample_valid strobe
// Notes: one wait state on every APB access; pready rises one cycle into access
module delta_outputs #(
   parameter int SAMPLE_W = 32
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sensor samples
   input wire logic sample_valid,
   input wire logic [SAMPLE_W-1:0] rate_x,
   input wire logic [SAMPLE_W-1:0] rate_y,
   input wire logic [SAMPLE_W-1:0] rate_z,
   input wire logic [SAMPLE_W-1:0] accel_x,
   // decimation from the setting register outside
   input wire logic [delta_pkg::DEC_W-1:0] decimation_setting,
   // new results loaded
   output logic data_update
);
   localparam int NCH = 4;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic en_q;
   logic [1:0] range_q;
   logic [15:0] count_q;
   logic [31:0] hold_q [NCH];
   logic [31:0] res [NCH];
   logic [SAMPLE_W-1:0] samp [NCH];
   logic [delta_pkg::COEF_W-1:0] coef [NCH];
   logic [delta_pkg::COEF_W-1:0] ang_coef;
   logic dump_d_q;
   logic update_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   seq_if sif ();

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [delta_pkg::COEF_W-1:0] range_coef(input logic [1:0] r);
      unique case (r)
         delta_pkg::RANGE_LOW: return delta_pkg::COEF_ANG_LOW;
         delta_pkg::RANGE_MID: return delta_pkg::COEF_ANG_MID;
         default: return delta_pkg::COEF_ANG_HIGH;
      endcase
   endfunction

   function automatic logic is_result(input logic [5:0] idx);
      return idx inside {delta_pkg::IDX_ROLL_LO, delta_pkg::IDX_ROLL_HI,
                         delta_pkg::IDX_PITCH_LO, delta_pkg::IDX_PITCH_HI,
                         delta_pkg::IDX_YAW_LO, delta_pkg::IDX_YAW_HI,
                         delta_pkg::IDX_XVEL_LO, delta_pkg::IDX_XVEL_HI};
   endfunction

   // ----------------------------------------------------------------
   // integration datapath
   // ----------------------------------------------------------------
   assign ang_coef = range_coef(range_q);
   assign samp[0] = rate_x;
   assign samp[1] = rate_y;
   assign samp[2] = rate_z;
   assign samp[3] = accel_x;
   assign coef[0] = ang_coef;
   assign coef[1] = ang_coef;
   assign coef[2] = ang_coef;
   assign coef[3] = delta_pkg::COEF_VEL;

   sample_sequencer u_seq (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .enable(en_q),
      .sample_valid(sample_valid),
      .decimation(decimation_setting),
      .seq(sif.src)
   );

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      trap_integrator #(.SAMPLE_W(SAMPLE_W)) u_int (
         .ref_clk(ref_clk),
         .resetn(resetn),
         .seq(sif.sink),
         .sample(samp[c]),
         .coef(coef[c]),
         .result_q(res[c])
      );
   end

   // ----------------------------------------------------------------
   // output hold registers and update counter
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         dump_d_q <= 1'b0;
      end else begin
         dump_d_q <= sif.dump;
      end
   end

   // all four words load on one edge: a read pair after an update is coherent
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         for (int i = 0; i < NCH; i++) begin
            hold_q[i] <= delta_pkg::RESULT_RESET;
         end
      end else if (dump_d_q) begin
         for (int i = 0; i < NCH; i++) begin
            hold_q[i] <= res[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         count_q <= delta_pkg::COUNT_RESET;
         update_q <= 1'b0;
      end else begin
         update_q <= dump_d_q;
         if (dump_d_q) begin
            count_q <= count_q + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   logic access;
   logic [5:0] idx;
   logic aligned;
   logic ctrl_hit;
   logic mapped;
   logic [15:0] rd_word;

   assign access = psel && penable && !pready_q;
   assign idx = paddr[7:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign ctrl_hit = aligned && (idx == delta_pkg::IDX_CTRL);
   assign mapped = aligned && (is_result(idx) || ctrl_hit || idx == delta_pkg::IDX_COUNT);

   always_comb begin
      rd_word = 16'h0000;
      unique case (idx)
         delta_pkg::IDX_ROLL_LO: rd_word = hold_q[0][15:0];
         delta_pkg::IDX_ROLL_HI: rd_word = hold_q[0][31:16];
         delta_pkg::IDX_PITCH_LO: rd_word = hold_q[1][15:0];
         delta_pkg::IDX_PITCH_HI: rd_word = hold_q[1][31:16];
         delta_pkg::IDX_YAW_LO: rd_word = hold_q[2][15:0];
         delta_pkg::IDX_YAW_HI: rd_word = hold_q[2][31:16];
         delta_pkg::IDX_XVEL_LO: rd_word = hold_q[3][15:0];
         delta_pkg::IDX_XVEL_HI: rd_word = hold_q[3][31:16];
         delta_pkg::IDX_CTRL: rd_word = {13'h0000, range_q, en_q};
         delta_pkg::IDX_COUNT: rd_word = count_q;
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= access;
         if (access) begin
            // results and counter are read-only: writes to them are refused
            pslverr_q <= !mapped || (pwrite && !ctrl_hit);
            prdata_q <= (!pwrite && mapped) ? {16'h0000, rd_word} : 32'h0000_0000;
         end else begin
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   // range code 3 is not a variant; such a write keeps the old range
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         en_q <= delta_pkg::CTRL_EN_RESET;
         range_q <= delta_pkg::CTRL_RANGE_RESET;
      end else if (access && pwrite && ctrl_hit && pstrb[0]) begin
         en_q <= pwdata[delta_pkg::CTRL_EN_BIT];
         if (pwdata[delta_pkg::CTRL_RANGE_LSB +: 2] != 2'h3) begin
            range_q <= pwdata[delta_pkg::CTRL_RANGE_LSB +: 2];
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign data_update = update_q;
endmodule

/* delta_pkg.sv */
// Purpose: shared constants for the delta angle / delta velocity output block
// Assumes: 125 MHz ref_clk, registers reached over APB, one aligned word each
// Notes: printed offsets are register indices; byte address is four times index
//
// What this block does
// - delta velocity is trapezoidal sum of acceleration pairs, scaled by 1/(2*fs).
// - delta angle uses the same trapezoidal sum and scaling on rate samples.
// - samples summed per result equal decimation setting plus one.
// - internal sample clock integrates at nominal 2000 samples per second.
// - roll delta angle 32-bit: upper half index 0x26, lower half 0x24.
// - pitch delta angle lower half at 0x28, upper half at 0x2A.
// - yaw delta angle lower half at 0x2C, upper half at 0x2E.
// - upper word LSB is max delta angle over 2^15, 0x8000..0x7FFF.
// - max delta angle is 360, 720 or 2160 degrees by range variant.
// - 32-bit angle spans 0x80000000..0x7FFFFFFF, LSB is max over 2^31.
// - x delta velocity upper word at 0x32, extra resolution at 0x30.
// - velocity upper word spans +/-100 m/sec, LSB 100/2^15.
// - two velocity registers combine into one 32-bit twos complement value.
package delta_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_ROLL_LO = 6'h24;
   localparam logic [5:0] IDX_ROLL_HI = 6'h26;
   localparam logic [5:0] IDX_PITCH_LO = 6'h28;
   localparam logic [5:0] IDX_PITCH_HI = 6'h2A;
   localparam logic [5:0] IDX_YAW_LO = 6'h2C;
   localparam logic [5:0] IDX_YAW_HI = 6'h2E;
   localparam logic [5:0] IDX_XVEL_LO = 6'h30;
   localparam logic [5:0] IDX_XVEL_HI = 6'h32;
   localparam logic [5:0] IDX_CTRL = 6'h3C;
   localparam logic [5:0] IDX_COUNT = 6'h3E;

   // ----------------------------------------------------------------
   // control field layout and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_RANGE_LSB = 1;
   localparam logic [1:0] RANGE_LOW = 2'h0;
   localparam logic [1:0] RANGE_MID = 2'h1;
   localparam logic [1:0] RANGE_HIGH = 2'h2;
   localparam logic CTRL_EN_RESET = 1'h1;
   localparam logic [1:0] CTRL_RANGE_RESET = 2'h0;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // scaling: samples carry 16 fraction bits (deg/s or m/s^2)
   // coef = 2^(15+FRAC_W) / (2 * fs * full_scale), applied as Q(FRAC_W)
   // ----------------------------------------------------------------
   localparam int DEC_W = 16;
   localparam int COEF_W = 24;
   localparam int FRAC_W = 24;
   localparam longint NOMINAL_SPS = 2000;
   localparam longint ANG_MAX_LOW = 360;
   localparam longint ANG_MAX_MID = 720;
   localparam longint ANG_MAX_HIGH = 2160;
   localparam longint VEL_MAX = 100;
   localparam longint COEF_NUM = longint'(1) << (15 + FRAC_W);
   localparam logic [COEF_W-1:0] COEF_ANG_LOW = COEF_W'(COEF_NUM / (2 * NOMINAL_SPS * ANG_MAX_LOW));
   localparam logic [COEF_W-1:0] COEF_ANG_MID = COEF_W'(COEF_NUM / (2 * NOMINAL_SPS * ANG_MAX_MID));
   localparam logic [COEF_W-1:0] COEF_ANG_HIGH = COEF_W'(COEF_NUM / (2 * NOMINAL_SPS * ANG_MAX_HIGH));
   localparam logic [COEF_W-1:0] COEF_VEL = COEF_W'(COEF_NUM / (2 * NOMINAL_SPS * VEL_MAX));

   // clock cycles per nominal sample, for reference by benches
   localparam longint CLK_HZ = 125_000_000;
   localparam int CYCLES_PER_SAMPLE = int'(CLK_HZ / NOMINAL_SPS);

   // clamp a wide signed value into 32-bit twos complement
   function automatic logic [31:0] sat32(input logic signed [127:0] v);
      if (v > 128'sh7FFF_FFFF) begin
         return 32'h7FFF_FFFF;
      end else if (v < -128'sh8000_0000) begin
         return 32'h8000_0000;
      end
      return v[31:0];
   endfunction

endpackage

/* seq_if.sv */
// Purpose: carries decimation timing from sequencer to the integrators
// Assumes: single clock domain
// Notes: add and dump are combinational single-cycle strobes
interface seq_if;
   logic add;
   logic dump;
   logic clear;
   modport src (output add, output dump, output clear);
   modport sink (input add, input dump, input clear);
endinterface

/* sample_sequencer.sv */
// Purpose: counts input samples over one decimation span
// Assumes: sample_valid is a one-cycle strobe per sensor sample
// Notes: decimation is latched at the start of each span
module sample_sequencer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // control
   input wire logic enable,
   input wire logic sample_valid,
   input wire logic [delta_pkg::DEC_W-1:0] decimation,
   // strobes to integrators
   seq_if.src seq
);
   typedef enum logic [0:0] {ST_OFF = 1'b0, ST_RUN = 1'b1} seq_state_t;
   seq_state_t state_q;
   logic [delta_pkg::DEC_W-1:0] dec_q;
   logic [delta_pkg::DEC_W-1:0] cnt_q;

   assign seq.add = (state_q == ST_RUN) && sample_valid;
   assign seq.dump = seq.add && (cnt_q == dec_q);
   assign seq.clear = (state_q == ST_OFF);

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_q <= ST_OFF;
         dec_q <= '0;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               if (enable) begin
                  state_q <= ST_RUN;
                  dec_q <= decimation;
                  cnt_q <= '0;
               end
            end
            ST_RUN: begin
               if (!enable) begin
                  state_q <= ST_OFF;
               end else if (seq.dump) begin
                  // span of decimation + 1 samples closes here
                  cnt_q <= '0;
                  dec_q <= decimation;
               end else if (seq.add) begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         endcase
      end
   end
endmodule

/* trap_integrator.sv */
// Purpose: trapezoidal sum of one channel, scaled to a 32-bit result
// Assumes: samples are signed with 16 fraction bits
// Notes: previous sample carries over span boundaries, as the pair sum needs
module trap_integrator #(
   parameter int SAMPLE_W = 32
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // strobes
   seq_if.sink seq,
   // data
   input wire logic signed [SAMPLE_W-1:0] sample,
   input wire logic [delta_pkg::COEF_W-1:0] coef,
   output logic [31:0] result_q
);
   localparam int ACC_W = SAMPLE_W + delta_pkg::DEC_W + 2;
   localparam int PROD_W = ACC_W + delta_pkg::COEF_W + 1;

   if (SAMPLE_W < 8 || SAMPLE_W > 40) begin : g_bad_width
      $error("trap_integrator: SAMPLE_W out of range");
   end

   logic signed [SAMPLE_W-1:0] prev_q;
   logic signed [ACC_W-1:0] acc_q;
   logic signed [ACC_W-1:0] pair;
   logic signed [ACC_W-1:0] total;
   logic signed [PROD_W-1:0] prod;

   assign pair = ACC_W'(sample) + ACC_W'(prev_q);
   assign total = acc_q + pair;
   assign prod = PROD_W'(total) * PROD_W'($signed({1'b0, coef}));

   always_ff @(posedge ref_clk) begin
      if (!resetn || seq.clear) begin
         prev_q <= '0;
         acc_q <= '0;
      end else if (seq.add) begin
         prev_q <= sample;
         acc_q <= seq.dump ? '0 : total;
      end
   end

   // one register holds the whole word so both halves always match
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         result_q <= delta_pkg::RESULT_RESET;
      end else if (seq.dump) begin
         result_q <= delta_pkg::sat32(128'(prod >>> delta_pkg::FRAC_W));
      end
   end
endmodule

/* delta_outputs_asserts.sv */
// Purpose: port-level checks on the delta result block
// Assumes: one wait state per apb access, results read from 0x90..0xC8
// Notes: bound from the bench top file
module delta_outputs_asserts (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // samples and updates
   input wire logic sample_valid,
   input wire logic data_update
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic acc;
   // first access cycle, before the answer
   assign acc = psel && penable && !pready;
   // ----------------------------------------------------------------
   // apb answer
   // ----------------------------------------------------------------
   a_ready_wait: assert property (acc |=> pready)
      else $error("ready missing after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_cause: assert property (pready |-> $past(acc))
      else $error("ready without access");
   a_idle_data: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read bits set");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   // result registers are read-only
   a_ro_write: assert property (acc && pwrite && paddr >= 8'h90 && paddr <= 8'hC8
      |=> pslverr)
      else $error("result write not refused");
   // ----------------------------------------------------------------
   // update timing
   // ----------------------------------------------------------------
   a_update_cause: assert property (data_update |-> $past(sample_valid, 2))
      else $error("update without sample");
   a_update_once: assert property (data_update && !$past(sample_valid) |=> !data_update)
      else $error("update stretched");
   cover property (data_update);
   cover property (pready && pslverr);
   cover property (pready && !pwrite);
endmodule

/* sample_src.sv */
// Purpose: sensor front end feeding rate and accel samples
// Assumes: caller enters send just after a rising edge
// Notes: channels carry inverted data once the strobe is gone
module sample_src (
   // clock
   input wire logic ref_clk,
   // samples toward the block
   output logic sample_valid,
   output logic [31:0] rate_x,
   output logic [31:0] rate_y,
   output logic [31:0] rate_z,
   output logic [31:0] accel_x
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sample_valid = 1'b0;
      {rate_x, rate_y, rate_z, accel_x} = 128'h0;
   end
   task automatic send(input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] c, input logic [31:0] d);
      sample_valid <= 1'b1;
      {rate_x, rate_y, rate_z, accel_x} <= {a, b, c, d};
      @(posedge ref_clk);
      // not held past the strobe, so stale data cannot pass
      sample_valid <= 1'b0;
      {rate_x, rate_y, rate_z, accel_x} <= ~{a, b, c, d};
      @(posedge ref_clk);
   endtask
endmodule

/* tb.sv */
// Purpose: register-level tests of the delta result block
// Assumes: samples carry 16 fraction bits, coef per full scale
// Notes: decimation changes go with a disable/enable pair
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, sample_valid, data_update;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rate_x, rate_y, rate_z, accel_x, r;
   logic [15:0] decimation;
   logic [3:0] pstrb;
   logic e;
   int n_mismatch, tests_run, n_upd, n_rate;
   longint prev[4];
   delta_outputs dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .rate_x(rate_x),
      .rate_y(rate_y), .rate_z(rate_z), .accel_x(accel_x),
      .decimation_setting(decimation), .data_update(data_update));
   sample_src src (.ref_clk(ref_clk), .sample_valid(sample_valid), .rate_x(rate_x),
      .rate_y(rate_y), .rate_z(rate_z), .accel_x(accel_x));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (data_update === 1'b1) n_upd <= n_upd + 1;
   end
   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) chk("pready", 32'h1, 32'h0);
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      if (!xe) chk("prdata", x, r);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
      apb(1'b1, a, d);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask
   function automatic longint coef(input int i, input logic [1:0] rng);
      longint fs;
      fs = (i == 3) ? 100 : (rng == 2'h0) ? 360 : (rng == 2'h1) ? 720 : 2160;
      return (longint'(1) << 39) / (2 * 2000 * fs);
   endfunction
   // n samples of one value set; expectation from the trapezoidal sum
   task automatic span(input int n, input longint v0, input longint v1, input longint v2,
                       input longint v3, input logic [1:0] rng, input bit cfg);
      longint v[4];
      longint s;
      logic [31:0] x[4];
      int u;
      int k;
      v = '{v0, v1, v2, v3};
      if (cfg) begin
         decimation <= 16'(n - 1);
         wr(8'hF0, 32'h0, 1'b0);
         wr(8'hF0, {29'h0, rng, 1'b1}, 1'b0);
         prev = '{0, 0, 0, 0};
      end
      for (int i = 0; i < 4; i++) begin
         s = v[i] + prev[i] + 2 * (n - 1) * v[i];
         x[i] = 32'((s * coef(i, rng)) >>> 24);
         prev[i] = v[i];
      end
      u = n_upd;
      repeat (n) src.send(32'(v0), 32'(v1), 32'(v2), 32'(v3));
      k = 0;
      while (n_upd != u + 1 && k < 20) begin
         @(posedge ref_clk);
         k++;
      end
      repeat (4) @(posedge ref_clk);
      chk("updates", 32'(u + 1), 32'(n_upd));
      for (int i = 0; i < 4; i++) begin
         rd(8'h90 + 8'(16 * i), {16'h0, x[i][15:0]}, 1'b0);
         rd(8'h98 + 8'(16 * i), {16'h0, x[i][31:16]}, 1'b0);
      end
   endtask
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata, decimation} = 0;
      {n_mismatch, tests_run, n_upd} = 0;
      pstrb = 4'hF;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 8; i++) rd(8'h90 + 8'(8 * i), 32'h0, 1'b0);
      rd(8'hF0, 32'h1, 1'b0);
      rd(8'hF8, 32'h0, 1'b0);
      rd(8'hD0, 32'h0, 1'b1);
      rd(8'h91, 32'h0, 1'b1);
      wr(8'h98, 32'h1234, 1'b1);
      rd(8'h98, 32'h0, 1'b0);
      // ctrl write without byte lane 0 completes but changes nothing
      pstrb <= 4'h0;
      wr(8'hF0, 32'h0, 1'b0);
      pstrb <= 4'hF;
      rd(8'hF0, 32'h1, 1'b0);
      // range code 3 is no variant: enable lands, range stays
      wr(8'hF0, 32'h7, 1'b0);
      rd(8'hF0, 32'h1, 1'b0);
      span(1, 64'h10000, -64'sh20000, 64'h30000, 64'h8000, 2'h0, 1'b1);
      span(3, -64'sh18000, 64'h4000, 64'h0, -64'sh24000, 2'h0, 1'b1);
      span(3, 64'h7000, 64'h1000, -64'sh9000, 64'h2000, 2'h0, 1'b0);
      for (int g = 1; g < 3; g++) begin
         span(1, 64'h50000, -64'sh50000, 64'h1000, 64'h3000, 2'(g), 1'b1);
      end
      // decimation zero: one update per sample gives the host the true rate
      n_rate = n_upd;
      repeat (4) src.send(32'h100, 32'h100, 32'h100, 32'h100);
      repeat (6) @(posedge ref_clk);
      chk("rate updates", 32'(n_rate + 4), 32'(n_upd));
      // disabled: samples must not load new results
      wr(8'hF0, 32'h0, 1'b0);
      src.send(32'h10000, 32'h10000, 32'h10000, 32'h10000);
      repeat (6) @(posedge ref_clk);
      chk("idle updates", 32'h9, 32'(n_upd));
      rd(8'hF8, 32'h9, 1'b0);
      print_verdict;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      print_verdict;
   end
endmodule
bind delta_outputs delta_outputs_asserts watch (.ref_clk(ref_clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
   .data_update(data_update));
